/* hw/config_port_front_end.v */
// Front end of a configuration port: clear sequencing, preamble and length
// counting, sync-word recognition, byte-wide and serial load and readback.
// Assumes the host drives the shift clock (320 ns period) far slower than
// i_clk_sys; pin inputs other than i_byte_mode, i_data_error and i_cfg_done are sampled with three flip-flops.
// Function
// [RULE_01] The 4-bit pattern 0010 is recognised as the start of the length field.
// [RULE_02] Bits received before that pattern are discarded as data.
// [RULE_03] The bit length counter advances on every shift clock rise, preamble or not; rises in clear, hold and readback are not counted.
// [RULE_04] While clear input is low, memory keeps clearing and clear status is low.
// [RULE_05] On clear release, finish current cycle, run one more, hold, then release status.
// [RULE_06] Direction low writes data in, high reads data out, and the device follows.
// [RULE_07] A direction change when not expected aborts the current operation.
// [RULE_08] Configuration logic synchronises on a dedicated 32-bit sync word.
// [RULE_09] Readback shifts memory out serially or one byte per clock on the parallel port.
// [RULE_10] Readback data is grouped into the same frames used for writing.
// [RULE_11] After configuration the parallel pins are released or kept, by option.
// [RULE_12] During configuration a data error pulls the clear status output low.
// [RULE_13] The host may hold clear status low to keep the device in hold.
// [RULE_14] Words are 32 bits and frames are padded to a whole number of words.
// [RULE_15] After an abort, data is ignored until the sync word is seen again.
`timescale 1ns/10ps
`include "cfg_front_defines.vh"
module config_port_front_end #(
    parameter [31:0] SYNC_WORD = 32'hA5C3_0F96, // arbitrary value
    parameter FRAME_WORDS = 4,
    parameter MEM_WORDS = 64,
    parameter ADDR_W = 6,
    parameter KEEP_PORT = 1'b0
)(
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_clear_n,
    input wire i_status_n,
    input wire i_cfg_shift_clock,
    input wire i_dir_read,
    input wire i_din_serial,
    input wire [7:0] i_data,
    input wire i_byte_mode,
    input wire i_data_error,
    input wire i_cfg_done,
    output wire o_status_n_out,
    output wire o_status_n_oe,
    output reg [7:0] o_data,
    output reg o_data_oe,
    output reg o_dout_serial,
    output reg [31:0] o_length_count,
    output reg o_synced,
    output reg o_abort,
    output reg o_port_released,
    output reg [31:0] o_word,
    output reg o_word_valid
);
    // Three-stage samplers; stage 1 is read only by stage 2
    reg [2:0] clk_s_r;
    reg [2:0] clr_s_r;
    reg [2:0] stat_s_r;
    reg [2:0] dir_s_r;
    reg [2:0] ser_s_r;
    reg [7:0] dat1_r;
    reg [7:0] dat2_r;
    reg [7:0] dat3_r;
    reg clk_q_r;
    reg clr_q_r;
    reg stat_q_r;
    reg dir_q_r;
    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            clk_s_r <= 3'h0;
            clr_s_r <= 3'h7;
            stat_s_r <= 3'h7;
            dir_s_r <= 3'h0;
            ser_s_r <= 3'h0;
            dat1_r <= 8'h00;
            dat2_r <= 8'h00;
            dat3_r <= 8'h00;
            clk_q_r <= 1'b0;
            clr_q_r <= 1'b1;
            stat_q_r <= 1'b1;
            dir_q_r <= 1'b0;
        end
        else
        begin
            clk_s_r <= {clk_s_r[1:0], i_cfg_shift_clock};
            clr_s_r <= {clr_s_r[1:0], i_clear_n};
            stat_s_r <= {stat_s_r[1:0], i_status_n};
            dir_s_r <= {dir_s_r[1:0], i_dir_read};
            ser_s_r <= {ser_s_r[1:0], i_din_serial};
            dat1_r <= i_data;
            dat2_r <= dat1_r;
            dat3_r <= dat2_r;
            if (clk_s_r[1] == clk_s_r[2])
                clk_q_r <= clk_s_r[2];
            if (clr_s_r[1] == clr_s_r[2])
                clr_q_r <= clr_s_r[2];
            if (stat_s_r[1] == stat_s_r[2])
                stat_q_r <= stat_s_r[2];
            if (dir_s_r[1] == dir_s_r[2])
                dir_q_r <= dir_s_r[2];
        end
    end

    // Rise is seen only once stages 2 and 3 agree high
    wire clk_rise = clk_s_r[1] & clk_s_r[2] & ~clk_q_r;
    wire dir_now = (dir_s_r[1] == dir_s_r[2]) ? dir_s_r[2] : dir_q_r;
    // Compared against the filtered level so one-cycle glitches never abort
    wire dir_change = dir_now != dir_q_r;

    reg [2:0] state_r;
    reg [`CLEAR_CNT_W-1:0] clr_cnt_r;
    reg [`PREAMBLE_W-1:0] pre_sh_r;
    reg pre_found_r;
    reg [31:0] word_sh_r;
    reg [5:0] bit_cnt_r;
    reg [31:0] mem_r [0:MEM_WORDS-1];
    reg [ADDR_W-1:0] wr_addr_r;
    reg [ADDR_W-1:0] rd_addr_r;
    reg [31:0] rd_sh_r;
    reg [5:0] rd_bits_r;
    reg err_r;
    integer k;
    // Sized copies of the header counts so no assignment pads or cuts
    localparam [5:0] WORD_BITS = `WORD_W;
    localparam [5:0] BYTE_BITS = 6'd8;

    wire in_bit = ser_s_r[2];
    wire [5:0] step = i_byte_mode ? BYTE_BITS : 6'd1;
    // Readback may turn back to writing only on a frame boundary
    wire frame_edge = (rd_addr_r % FRAME_WORDS) == 0;
    wire [31:0] word_nxt = i_byte_mode ? {word_sh_r[23:0], dat3_r}
                                       : {word_sh_r[30:0], in_bit};
    wire clr_last = clr_cnt_r == (`CLEAR_CYCLES - 1);

    // Open-drain status: low while clearing or on error
    assign o_status_n_oe = (state_r == `ST_CLEAR) | (state_r == `ST_CLEAR_LAST)
                         | err_r; // RULE_04 RULE_12
    assign o_status_n_out = 1'b0;

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state_r <= `ST_CLEAR;
            clr_cnt_r <= {`CLEAR_CNT_W{1'b0}};
            pre_sh_r <= {`PREAMBLE_W{1'b1}};
            pre_found_r <= 1'b0;
            word_sh_r <= 32'h00000000;
            bit_cnt_r <= 6'd0;
            wr_addr_r <= {ADDR_W{1'b0}};
            rd_addr_r <= {ADDR_W{1'b0}};
            rd_sh_r <= 32'h00000000;
            rd_bits_r <= 6'd0;
            err_r <= 1'b0;
            o_length_count <= `LEN_CNT_RST;
            o_synced <= 1'b0;
            o_abort <= 1'b0;
            o_port_released <= 1'b0;
            o_word <= 32'h00000000;
            o_word_valid <= 1'b0;
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
            o_dout_serial <= 1'b0;
        end
        else
        begin
            o_word_valid <= 1'b0;
            if (!clr_q_r)
            begin
                // Clearing continues while held low
                state_r <= `ST_CLEAR; // RULE_04
                err_r <= 1'b0;
                o_synced <= 1'b0;
                o_abort <= 1'b0;
                o_port_released <= 1'b0;
                o_data_oe <= 1'b0;
                o_length_count <= `LEN_CNT_RST;
                pre_found_r <= 1'b0;
                pre_sh_r <= {`PREAMBLE_W{1'b1}};
            end
            case (state_r)
                `ST_CLEAR, `ST_CLEAR_LAST:
                begin
                    clr_cnt_r <= clr_last ? {`CLEAR_CNT_W{1'b0}}
                                          : clr_cnt_r + 1'b1;
                    // Whole array each cycle; costs area, keeps clear time short
                    for (k = 0; k < MEM_WORDS; k = k + 1)
                        mem_r[k] <= 32'h00000000; // RULE_04
                    // Finish this pass, then one more full pass
                    if (clr_last && clr_q_r)
                        state_r <= (state_r == `ST_CLEAR) ? `ST_CLEAR_LAST
                                                          : `ST_HOLD; // RULE_05
                end
                `ST_HOLD:
                    if (stat_q_r) // RULE_13
                        state_r <= `ST_HUNT;
                `ST_HUNT, `ST_SYNC, `ST_WRITE, `ST_ABORT:
                    if (clk_rise && clr_q_r)
                    begin
                        o_length_count <= o_length_count + 32'd1; // RULE_03
                        pre_sh_r <= {pre_sh_r[`PREAMBLE_W-2:0], in_bit};
                        if (!pre_found_r)
                        begin
                            // Leading bits counted only, not kept
                            if ({pre_sh_r[`PREAMBLE_W-2:0], in_bit} == `PREAMBLE_PAT)
                                pre_found_r <= 1'b1; // RULE_01 RULE_02
                        end
                        else
                        begin
                            word_sh_r <= word_nxt;
                            if (state_r != `ST_WRITE)
                            begin
                                // Hunt one bit or byte per rise; keeps hunting after abort
                                if (word_nxt == SYNC_WORD)
                                begin
                                    state_r <= `ST_WRITE; // RULE_08 RULE_15
                                    o_synced <= 1'b1;
                                    o_abort <= 1'b0;
                                    bit_cnt_r <= 6'd0;
                                    wr_addr_r <= {ADDR_W{1'b0}};
                                end
                            end
                            else if (bit_cnt_r + step >= `WORD_W)
                            begin
                                // Whole 32-bit words only; pad bits fill frames
                                bit_cnt_r <= 6'd0; // RULE_14
                                o_word <= word_nxt;
                                o_word_valid <= 1'b1;
                                mem_r[wr_addr_r] <= word_nxt;
                                wr_addr_r <= wr_addr_r + 1'b1;
                            end
                            else
                                bit_cnt_r <= bit_cnt_r + step;
                        end
                        if (i_data_error && state_r == `ST_WRITE)
                            err_r <= 1'b1; // RULE_12
                    end
                // First rise loads a word, later rises shift it out
                `ST_READ:
                    if (clk_rise)
                    begin
                        if (rd_bits_r == 6'd0)
                        begin
                            // Whole frames from frame start
                            rd_sh_r <= mem_r[rd_addr_r]; // RULE_09 RULE_10
                            rd_addr_r <= rd_addr_r + 1'b1;
                            rd_bits_r <= WORD_BITS;
                        end
                        else if (i_byte_mode)
                        begin
                            o_data <= rd_sh_r[31:24]; // RULE_09
                            rd_sh_r <= {rd_sh_r[23:0], 8'h00};
                            rd_bits_r <= rd_bits_r - BYTE_BITS;
                        end
                        else
                        begin
                            o_dout_serial <= rd_sh_r[31];
                            rd_sh_r <= {rd_sh_r[30:0], 1'b0};
                            rd_bits_r <= rd_bits_r - 6'd1;
                        end
                    end
                default:
                    state_r <= `ST_CLEAR;
            endcase
            if (clr_q_r && dir_change)
            begin
                // Direction only expected to flip between words when synced
                if (o_synced && state_r == `ST_WRITE && bit_cnt_r == 6'd0
                    && dir_now)
                begin
                    state_r <= `ST_READ; // RULE_06
                    o_data_oe <= i_byte_mode & ~o_port_released;
                    rd_addr_r <= {ADDR_W{1'b0}};
                    rd_bits_r <= 6'd0;
                end
                else if (state_r == `ST_READ && !dir_now
                         && rd_bits_r == 6'd0
                         && frame_edge)
                begin
                    state_r <= `ST_WRITE; // RULE_06
                    o_data_oe <= 1'b0;
                end
                else if (state_r != `ST_CLEAR && state_r != `ST_CLEAR_LAST
                         && state_r != `ST_HOLD)
                begin
                    state_r <= `ST_ABORT; // RULE_07 RULE_15
                    o_abort <= 1'b1;
                    o_synced <= 1'b0;
                    o_data_oe <= 1'b0;
                end
            end

            // Option set keeps the pins working as the config port
            if (i_cfg_done && clr_q_r && !o_port_released && !KEEP_PORT)
            begin
                o_port_released <= 1'b1; // RULE_11
                o_data_oe <= 1'b0;
            end
        end
    end
endmodule

/* include/cfg_front_defines.vh */
// Constants for the configuration port front end.
// Included by hw/config_port_front_end.v only; definitions only.
`ifndef CFG_FRONT_DEFINES_VH
`define CFG_FRONT_DEFINES_VH
`define PREAMBLE_W 4
`define PREAMBLE_PAT 4'h2
`define WORD_W 32
`define LEN_CNT_W 32
`define LEN_CNT_RST 32'h00000000
`define CLEAR_CYCLES 16
`define CLEAR_CNT_W 8
`define ST_CLEAR 3'h0
`define ST_CLEAR_LAST 3'h1
`define ST_HOLD 3'h2
`define ST_HUNT 3'h3
`define ST_SYNC 3'h4
`define ST_WRITE 3'h5
`define ST_READ 3'h6
`define ST_ABORT 3'h7
`endif

/* tb/cfg_front_monitor.sv */
// Concurrent checks on the configuration port front end's pins.
// Assumes the host shift clock runs far slower than i_clk_sys.
`timescale 1ns/10ps
module cfg_front_monitor (
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_clear_n,
    input wire i_status_n,
    input wire i_dir_read,
    input wire i_byte_mode,
    input wire o_status_n_out,
    input wire o_status_n_oe,
    input wire o_data_oe,
    input wire [31:0] o_length_count,
    input wire o_synced,
    input wire o_abort,
    input wire o_port_released,
    input wire o_word_valid
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    logic dir_prev_r;
    logic [3:0] dir_age_r;
    // Age of the last direction change; saturates so it never wraps
    always @(posedge i_clk_sys)
    begin
        dir_prev_r <= i_dir_read;
        if (i_reset || i_dir_read == dir_prev_r)
            dir_age_r <= (dir_age_r == 4'hF || i_reset) ? 4'hF : dir_age_r + 4'h1;
        else
            dir_age_r <= 4'h0;
    end
    a_pin_low: assert property (o_status_n_out == 1'b0)
        else $error("status pin value not low");
    a_clear_pulls: assert property (!i_clear_n [*6] |-> o_status_n_oe)
        else $error("status not pulled while clearing");
    a_clear_tail: assert property ($rose(i_clear_n) |-> o_status_n_oe [*8])
        else $error("status released before clear passes end");
    a_len_step: assert property ($changed(o_length_count) |->
        o_length_count == $past(o_length_count) + 32'h1 || o_length_count == 32'h0)
        else $error("length counter jumped");
    a_hold_still: assert property (!i_status_n && o_length_count == 32'h0 |=>
        o_length_count == 32'h0)
        else $error("counting while held");
    a_valid_pulse: assert property (o_word_valid |=> !o_word_valid)
        else $error("word valid longer than one cycle");
    a_valid_synced: assert property (o_word_valid |-> o_synced && !o_abort)
        else $error("word taken while not synced");
    a_abort_cause: assert property ($rose(o_abort) |-> dir_age_r < 4'hC)
        else $error("abort without direction change");
    a_released_off: assert property (o_port_released |-> !o_data_oe)
        else $error("released pins still driven");
    a_oe_byte: assert property (o_data_oe |-> i_byte_mode)
        else $error("parallel pins driven in serial mode");
    c_word: cover property (o_word_valid);
    c_abort: cover property ($rose(o_abort));
    c_read: cover property (o_data_oe);
    c_release: cover property ($rose(o_port_released));
endmodule
bind config_port_front_end cfg_front_monitor mon (.*);

/* tb/cfg_host_model.sv */
// Configuration host: drives shift clock, data and direction pins.
// Assumes tasks are called at a falling edge of the 40 ns system clock.
`timescale 1ns/10ps
module cfg_host_model (
    input wire i_byte_mode,
    input wire [7:0] i_rd_byte,
    input wire i_rd_bit,
    output logic o_sclk = 1'b0,
    output logic o_din = 1'b0,
    output logic [7:0] o_dq = 8'h00,
    output logic o_dir = 1'b0
);
    // One 320 ns shift clock period; clock rests low between calls.
    // Captures what the device shows from the previous rise.
    task automatic xfer(input logic [7:0] v, output logic [7:0] seen);
        o_din = v[0];
        o_dq = v;
        #160;
        seen = i_byte_mode ? i_rd_byte : {7'h00, i_rd_bit};
        o_sclk = 1'b1;
        #160;
        o_sclk = 1'b0;
        // Released lines show the inverse so stale data cannot pass
        o_din = ~v[0];
        o_dq = ~v;
    endtask
    // Whole 32-bit words only, most significant first
    task automatic send_word(input logic [31:0] w);
        logic [31:0] t;
        logic [7:0] s;
        for (int i = 0; i < (i_byte_mode ? 4 : 32); i++)
        begin
            t = w << (i * (i_byte_mode ? 8 : 1));
            xfer(i_byte_mode ? t[31:24] : {7'h00, t[31]}, s);
        end
    endtask
    task automatic set_dir(input logic v);
        o_dir = v;
        #200;
    endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the configuration port front end.
// Assumes a pull-up on the status wire; the host model drives the link pins.
`timescale 1ns/10ps
module testbench;
    localparam logic [31:0] SYNC = 32'hF0F0_F0F0; // arbitrary value
    logic clk = 0, rst = 1, clear_n = 1, hold_n = 0, bm = 0, err = 0, done = 0;
    wire sclk, din, dir, st_oe, st_out, d_oe, dout, synced, abort_f, rel, wv;
    wire [7:0] dq, rd;
    wire [31:0] len, word;
    logic [31:0] last_w, got;
    logic [31:0] rows [4] = '{32'h0123_4567, 32'hFFFF_0000, 32'h8000_0001, 32'hDEAD_BEEF};
    logic [7:0] seen;
    int n_fail = 0, tests_run = 0, n_words = 0, cyc = 0;
    initial
    begin
        forever #20 clk = ~clk;
    end
    cfg_host_model host (.i_byte_mode(bm), .i_rd_byte(rd), .i_rd_bit(dout), .o_sclk(sclk),
        .o_din(din), .o_dq(dq), .o_dir(dir));
    config_port_front_end #(.SYNC_WORD(SYNC)) dut (.i_clk_sys(clk), .i_reset(rst),
        .i_clear_n(clear_n), .i_status_n(~st_oe & hold_n), .i_cfg_shift_clock(sclk),
        .i_dir_read(dir), .i_din_serial(din), .i_data(dq), .i_byte_mode(bm),
        .i_data_error(err), .i_cfg_done(done), .o_status_n_out(st_out), .o_status_n_oe(st_oe),
        .o_data(rd), .o_data_oe(d_oe), .o_dout_serial(dout), .o_length_count(len),
        .o_synced(synced), .o_abort(abort_f), .o_port_released(rel), .o_word(word),
        .o_word_valid(wv));
    always @(posedge clk)
    begin
        cyc++;
        if (wv === 1'b1)
        begin
            n_words++;
            last_w = word;
        end
        if (cyc == 30000)
        begin
            n_fail++;
            report_and_stop;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
        tests_run++;
        if (seen_v !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset(input logic b);
        rst = 1;
        bm = b;
        repeat (4) @(negedge clk);
        rst = 0;
        n_words = 0;
        @(negedge clk);
        check("oe_rst", st_oe, 1);
        for (int i = 0; i < 300 && st_oe !== 1'b0; i++)
            @(negedge clk);
    endtask
    task automatic load_rows;
        for (int i = 0; i < 4; i++)
        begin
            host.send_word(rows[i]);
            repeat (6) @(negedge clk);
            check("word", last_w, rows[i]);
            check("count", n_words, i + 1);
        end
    endtask
    initial
    begin
        @(negedge clk);
        do_reset(0);
        repeat (4) host.xfer(8'h00, seen);
        check("len_hold", len, 0);
        hold_n = 1;
        repeat (10) @(negedge clk);
        host.send_word(SYNC);
        check("sync_early", synced, 0);
        for (int i = 0; i < 4; i++)
            host.xfer({7'h00, i == 2}, seen);
        host.send_word(SYNC);
        check("synced", synced, 1);
        check("length", len, 68);
        load_rows();
        err = 1;
        host.send_word(rows[0]);
        err = 0;
        check("err_oe", st_oe, 1);
        host.set_dir(1);
        for (int k = 0; k < 10; k++)
        begin
            host.xfer(8'h00, seen);
            got = {got[30:0], seen[0]};
        end
        check("rd_bits", got[7:0], rows[0][31:24]);
        check("rd_ser_oe", d_oe, 0);
        clear_n = 0;
        repeat (5) @(negedge clk);
        host.set_dir(0);
        repeat (10) @(negedge clk);
        check("clr_oe", st_oe, 1);
        clear_n = 1;
        repeat (8) @(negedge clk);
        check("clr_tail", st_oe, 1);
        for (int i = 0; i < 200 && st_oe !== 1'b0; i++)
            @(negedge clk);
        check("clr_done", st_oe, 0);
        do_reset(1);
        for (int i = 0; i < 4; i++)
            host.xfer({7'h00, i == 2}, seen);
        host.send_word(SYNC);
        load_rows();
        host.set_dir(1);
        for (int k = 0; k < 6; k++)
        begin
            host.xfer(8'h00, seen);
            got = (k >= 2) ? {got[23:0], seen} : got;
        end
        check("rd_oe", d_oe, 1);
        check("rd_word", got, rows[0]);
        host.set_dir(0);
        repeat (6) @(negedge clk);
        check("abort", abort_f, 1);
        host.send_word(rows[1]);
        check("ignored", n_words, 4);
        host.send_word(SYNC);
        host.send_word(rows[2]);
        repeat (6) @(negedge clk);
        check("resync", last_w, rows[2]);
        done = 1;
        repeat (10) @(negedge clk);
        check("released", rel, 1);
        check("rel_oe", d_oe, 0);
        report_and_stop;
    end
endmodule
